// File: core/rlc_pkg.sv
// Shared constants, register map and types for the redriver lane control block
package rlc_pkg;

	// Register bus geometry
	localparam int        RLC_ADDR_W   = 8;
	localparam int        RLC_DATA_W   = 8;

	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_SWING    = 8'h04;
	localparam logic [7:0] REG_LANE1_EQ = 8'h08;
	localparam logic [7:0] REG_LANE2_EQ = 8'h0C;
	localparam logic [7:0] REG_STATUS   = 8'h10;

	// Control register fields
	localparam int        CTRL_LIMIT_BIT = 0;
	localparam int        CTRL_LIN_LSB   = 1;
	localparam int        CTRL_FLIP_BIT  = 3;
	localparam int        CTRL_X2_BIT    = 4;
	localparam logic [7:0] CTRL_RESET    = 8'h16;

	// Swing register fields
	localparam int        SWING_LSB      = 0;
	localparam logic [7:0] SWING_RESET   = 8'h00;

	// Per-lane transmit equalisation register fields
	localparam int        EQ_PS_LSB      = 0;
	localparam int        EQ_PS_ON_BIT   = 2;
	localparam int        EQ_DE_LSB      = 4;
	localparam int        EQ_DE_ON_BIT   = 6;
	localparam logic [7:0] EQ_RESET      = 8'h00;

	// Status register fields
	localparam int        ST_STATE_LSB   = 0;
	localparam int        ST_CFG_BIT     = 2;
	localparam int        ST_NC_ON_BIT   = 3;
	localparam int        ST_SERIAL_BIT  = 4;
	localparam int        ST_RSVD_BIT    = 5;
	localparam int        ST_DUAL_BIT    = 6;
	localparam int        ST_SLEEP_BIT   = 7;

	// Linearity range used when strapped
	localparam logic [1:0] LIN_TOP       = 2'h3;

	// Four-level strap pin codes
	localparam logic [1:0] LVL_0         = 2'h0;
	localparam logic [1:0] LVL_R         = 2'h1;
	localparam logic [1:0] LVL_F         = 2'h2;
	localparam logic [1:0] LVL_1         = 2'h3;

	// Timing
	localparam int        CLK_PERIOD_NS  = 20;
	localparam int        U1_DWELL_NS    = 1000;
	localparam int        U1_DWELL_CYC   = (U1_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] U1_DWELL_LAST = 6'(U1_DWELL_CYC - 1);
	localparam logic [2:0] STRAP_WAIT_LAST = 3'h4;

	// Synchronised pin vector width
	localparam int        SYNC_W         = 12;

	// Link power states
	typedef enum logic [1:0] {
		RLC_DISC,
		RLC_U0,
		RLC_U1,
		RLC_U23
	} rlc_pwr_t;

endpackage : rlc_pkg

// File: core/rlc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module rlc_pin_sync
	import rlc_pkg::*;
#(
	parameter int WIDTH = SYNC_W
)
(
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             reset,
	// Raw pins and filtered levels
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic stage1;
			logic stage2;
			logic stage3;
			logic level;
			logic next_level;

			// New level only counts once stages two and three agree
			always_comb
			begin
				next_level = level;
				if (stage2 == stage3)
				begin
					next_level = stage3;
				end
			end

			// First stage feeds only the second
			always_ff @(posedge ref_clk)
			begin
				if (reset)
				begin
					stage1 <= 1'b0;
					stage2 <= 1'b0;
					stage3 <= 1'b0;
					level  <= 1'b0;
				end
				else
				begin
					stage1 <= pin_in[i];
					stage2 <= stage1;
					stage3 <= stage2;
					level  <= next_level;
				end
			end

			assign pin_out[i] = level;
		end
	endgenerate

endmodule : rlc_pin_sync

// File: core/rlc_lane_ctrl.sv
// Mode, lane power and transmit setting control for the two-port redriver
//
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ns
// Behaviour
// R1 - Outputs linear by default, all transmitters
// R2 - Four linearity ranges; strapped uses top
// R3 - Limited mode only on host-side transmitters
// R4 - Limited off after reset until enabled
// R5 - Lane pre-shoot level gated by enables
// R6 - Lane de-emphasis level gated by enables
// R7 - No transmit equalisation in pin-strap mode
// R8 - Detect dual-lane; non-config lane follows
// R9 - Orientation alone picks config lane
// R10 - Non-config lane off in low power
// R11 - Config lane decides entry and exit
// R12 - Sleep low disables receiver detection
// R13 - Asleep in U3: terminate, ignore wake
// R14 - Asleep in disconnect: terminations off
// R15 - Sleep high resumes periodic detection
// R16 - Sleep acts on both ports
// R17 - Mode pin: F serial, 1 strap
// R18 - U2/U3 wakes on signaling, drops on loss
// R19 - Straps sampled once after reset
module rlc_lane_ctrl
	import rlc_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Straps and system pins
	input  wire logic [1:0] mode_level_pin,
	input  wire logic       flip_pin,
	input  wire logic       system_sleep_n,
	// Link sense per port
	input  wire logic [1:0] far_term_host,
	input  wire logic [1:0] far_term_conn,
	input  wire logic [1:0] lane_idle,
	input  wire logic [1:0] lane_lfps,
	// Mode status
	output logic            serial_mode,
	output logic            mode_reserved,
	output logic            config_lane,
	output logic [1:0]      link_state,
	output logic            dual_lane_active,
	// Lane power and receiver control
	output logic [1:0]      lane_on,
	output logic [1:0]      rx_term_en,
	output logic            rx_detect_en,
	// Transmitter settings
	output logic [1:0]      linearity_level,
	output logic [1:0]      host_tx_limited,
	output logic [1:0]      host_tx_swing_level,
	output logic [1:0]      tx_preshoot_on,
	output logic [3:0]      tx_preshoot_level,
	output logic [1:0]      tx_deemph_on,
	output logic [3:0]      tx_deemph_level
);

	logic [SYNC_W-1:0] sync_out;
	logic [1:0] s_mode;
	logic       s_flip;
	logic       s_sleep_n;
	logic       s_asleep;
	logic [1:0] s_term_h;
	logic [1:0] s_term_c;
	logic [1:0] s_idle;
	logic [1:0] s_lfps;

	// All pins cross into the clock domain here
	// Sleep crosses inverted so a cleared synchroniser reads awake, not asleep
	rlc_pin_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.ref_clk (ref_clk),
		.reset   (reset),
		.pin_in  ({mode_level_pin, flip_pin, ~system_sleep_n, far_term_host,
			far_term_conn, lane_idle, lane_lfps}),
		.pin_out (sync_out)
	);

	assign {s_mode, s_flip, s_asleep, s_term_h, s_term_c, s_idle, s_lfps} = sync_out;
	assign s_sleep_n = ~s_asleep;

	// Strap capture state
	logic [2:0] strap_cnt;
	logic       strap_done;
	logic [2:0] next_strap_cnt;
	logic       next_strap_done;
	logic       next_serial;
	logic       next_reserved;

	// Wait for the synchroniser to settle, then freeze the mode
	always_comb
	begin
		next_strap_cnt  = strap_cnt;
		next_strap_done = strap_done;
		next_serial     = serial_mode;
		next_reserved   = mode_reserved;
		if (!strap_done)
		begin
			if (strap_cnt == STRAP_WAIT_LAST)
			begin
				next_strap_done = 1'b1; // R19
				next_serial     = (s_mode == LVL_F); // R17
				next_reserved   = (s_mode == LVL_0) || (s_mode == LVL_R); // R17
			end
			else
			begin
				next_strap_cnt = strap_cnt + 3'h1;
			end
		end
	end

	// Reserved levels fall back to strap behaviour
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			strap_cnt     <= 3'h0;
			strap_done    <= 1'b0;
			serial_mode   <= 1'b0;
			mode_reserved <= 1'b0;
		end
		else
		begin
			strap_cnt     <= next_strap_cnt;
			strap_done    <= next_strap_done;
			serial_mode   <= next_serial;
			mode_reserved <= next_reserved;
		end
	end

	// Register file state
	logic [7:0] ctrl;
	logic [7:0] swing;
	logic [7:0] eq [2];
	logic [7:0] next_ctrl;
	logic [7:0] next_swing;
	logic [7:0] next_eq [2];
	logic [7:0] next_rdata;
	rlc_pwr_t   state;

	// Writes land only in serial mode; strapped parts still answer reads but ignore writes
	always_comb
	begin
		next_ctrl  = ctrl;
		next_swing = swing;
		next_eq[0] = eq[0];
		next_eq[1] = eq[1];
		next_rdata = 8'h00;
		if (reg_wr && serial_mode) // R7
		begin
			case (reg_addr)
				REG_CTRL:     next_ctrl  = reg_wdata;
				REG_SWING:    next_swing = reg_wdata;
				REG_LANE1_EQ: next_eq[0] = reg_wdata;
				REG_LANE2_EQ: next_eq[1] = reg_wdata;
				default:      next_ctrl  = ctrl;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				REG_CTRL:     next_rdata = ctrl;
				REG_SWING:    next_rdata = swing;
				REG_LANE1_EQ: next_rdata = eq[0];
				REG_LANE2_EQ: next_rdata = eq[1];
				REG_STATUS:
				begin
					next_rdata[ST_STATE_LSB +: 2] = link_state;
					next_rdata[ST_CFG_BIT]        = config_lane;
					next_rdata[ST_NC_ON_BIT]      = lane_on[~config_lane];
					next_rdata[ST_SERIAL_BIT]     = serial_mode;
					next_rdata[ST_RSVD_BIT]       = mode_reserved;
					next_rdata[ST_DUAL_BIT]       = dual_lane_active;
					next_rdata[ST_SLEEP_BIT]      = ~s_sleep_n;
				end
				default:      next_rdata = 8'h00;
			endcase
		end
	end

	// Limited mode enable resets clear
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			ctrl      <= CTRL_RESET; // R4
			swing     <= SWING_RESET;
			eq[0]     <= EQ_RESET;
			eq[1]     <= EQ_RESET;
			reg_rdata <= 8'h00;
		end
		else
		begin
			ctrl      <= next_ctrl;
			swing     <= next_swing;
			eq[0]     <= next_eq[0];
			eq[1]     <= next_eq[1];
			reg_rdata <= next_rdata;
		end
	end

	// Config lane and its link sense
	logic cfg;
	logic term_ok;
	logic idle_cfg;
	logic lfps_cfg;
	logic active_nc;
	logic x2_enable;
	logic limited;

	assign cfg       = serial_mode ? ctrl[CTRL_FLIP_BIT] : s_flip; // R9
	assign term_ok   = s_term_h[cfg] & s_term_c[cfg]; // R11
	assign idle_cfg  = s_idle[cfg]; // R11
	assign lfps_cfg  = s_lfps[cfg];
	assign active_nc = ~s_idle[~cfg];
	assign x2_enable = serial_mode ? ctrl[CTRL_X2_BIT] : 1'b1;
	assign limited   = serial_mode & ctrl[CTRL_LIMIT_BIT]; // R3

	// Power state machine group
	rlc_pwr_t   next_state;
	logic [5:0] dwell;
	logic [5:0] next_dwell;
	logic       next_dual;
	logic [1:0] next_lane_on;
	logic [1:0] next_term;
	logic       next_detect;

	// Only the config lane moves the state; the other lane just follows
	always_comb
	begin
		next_state = state;
		next_dwell = dwell;
		next_dual  = dual_lane_active;
		case (state)
			RLC_DISC:
			begin
				next_dual = 1'b0;
				if (s_sleep_n && term_ok) // R15
				begin
					next_state = RLC_U0;
				end
			end
			RLC_U0:
			begin
				if (x2_enable && active_nc)
				begin
					next_dual = 1'b1; // R8
				end
				if (!term_ok)
				begin
					next_state = RLC_DISC;
				end
				else if (idle_cfg)
				begin
					next_state = RLC_U1;
					next_dwell = 6'h00;
				end
			end
			RLC_U1:
			begin
				if (!term_ok)
				begin
					next_state = RLC_DISC;
				end
				else if (!idle_cfg || lfps_cfg)
				begin
					next_state = RLC_U0; // R11
				end
				else if (dwell == U1_DWELL_LAST)
				begin
					next_state = RLC_U23;
				end
				else
				begin
					next_dwell = dwell + 6'h01;
				end
			end
			RLC_U23:
			begin
				// Asleep: no detection and no wake, terminations stay on
				if (s_sleep_n && !term_ok)
				begin
					next_state = RLC_DISC; // R18
				end
				else if (s_sleep_n && lfps_cfg)
				begin
					next_state = RLC_U0; // R13 R18
				end
			end
			default:
			begin
				next_state = RLC_DISC;
			end
		endcase
		next_lane_on       = 2'b00;
		next_lane_on[cfg]  = 1'b1;
		next_lane_on[~cfg] = next_dual && (next_state == RLC_U0); // R8 R10 R11
		next_term          = (!s_sleep_n && next_state == RLC_DISC) ? 2'b00 : 2'b11; // R14 R16
		next_detect        = s_sleep_n && (next_state == RLC_DISC || next_state == RLC_U23); // R12 R15
	end

	// Lane outputs follow the next state so re-enable lands with the exit
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state            <= RLC_DISC;
			dwell            <= 6'h00;
			dual_lane_active <= 1'b0;
			lane_on          <= 2'b01;
			config_lane      <= 1'b0;
			rx_term_en       <= 2'b11;
			rx_detect_en     <= 1'b0;
		end
		else
		begin
			state            <= next_state;
			dwell            <= next_dwell;
			dual_lane_active <= next_dual;
			lane_on          <= next_lane_on;
			config_lane      <= cfg;
			rx_term_en       <= next_term;
			rx_detect_en     <= next_detect;
		end
	end

	assign link_state = state;

	// Shared transmitter settings
	logic [1:0] next_lin;
	logic [1:0] next_swing_lvl;

	// Connector-side transmitters always stay linear
	always_comb
	begin
		next_lin       = serial_mode ? ctrl[CTRL_LIN_LSB +: 2] : LIN_TOP; // R1 R2
		next_swing_lvl = limited ? swing[SWING_LSB +: 2] : 2'h0; // R4
	end

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			linearity_level     <= LIN_TOP;
			host_tx_swing_level <= 2'h0;
		end
		else
		begin
			linearity_level     <= next_lin;
			host_tx_swing_level <= next_swing_lvl;
		end
	end

	// Per host-side transmitter limited mode and equalisation
	genvar ln;
	generate
		for (ln = 0; ln < 2; ln++)
		begin : g_lane
			logic       next_lim;
			logic       next_ps_on;
			logic       next_de_on;
			logic [1:0] next_ps;
			logic [1:0] next_de;

			// Levels read zero whenever their gate is shut
			always_comb
			begin
				next_lim   = limited; // R3
				next_ps_on = limited & eq[ln][EQ_PS_ON_BIT]; // R5 R7
				next_de_on = limited & eq[ln][EQ_DE_ON_BIT]; // R6 R7
				next_ps    = next_ps_on ? eq[ln][EQ_PS_LSB +: 2] : 2'h0; // R5
				next_de    = next_de_on ? eq[ln][EQ_DE_LSB +: 2] : 2'h0; // R6
			end

			always_ff @(posedge ref_clk)
			begin
				if (reset)
				begin
					host_tx_limited[ln]           <= 1'b0;
					tx_preshoot_on[ln]            <= 1'b0;
					tx_deemph_on[ln]              <= 1'b0;
					tx_preshoot_level[2*ln +: 2]  <= 2'h0;
					tx_deemph_level[2*ln +: 2]    <= 2'h0;
				end
				else
				begin
					host_tx_limited[ln]           <= next_lim;
					tx_preshoot_on[ln]            <= next_ps_on;
					tx_deemph_on[ln]              <= next_de_on;
					tx_preshoot_level[2*ln +: 2]  <= next_ps;
					tx_deemph_level[2*ln +: 2]    <= next_de;
				end
			end
		end
	endgenerate

	// Checks on the block's own outputs
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_limit_reset_off: assert property ($past(reset) |-> host_tx_limited == 2'b00) // R4
		else $error("limited mode on right after reset");
	a_limit_swing_follow: assert property ($past(limited) |->
		host_tx_limited == 2'b11 && host_tx_swing_level == $past(swing[1:0])) // R3
		else $error("limited swing not taken from register");
	a_strap_lin_top: assert property (!$past(serial_mode) |-> linearity_level == LIN_TOP) // R2
		else $error("strapped linearity not at top");
	a_strap_no_txeq: assert property (!$past(serial_mode) |->
		tx_preshoot_on == 2'b00 && tx_deemph_on == 2'b00) // R7
		else $error("transmit equalisation active while strapped");
	a_lane1_preshoot: assert property (tx_preshoot_on[0] |->
		$past(limited && eq[0][EQ_PS_ON_BIT])) // R5
		else $error("lane 1 pre-shoot without enables");
	a_lane2_deemph: assert property ($past(limited && eq[1][EQ_DE_ON_BIT]) |->
		tx_deemph_on[1] && tx_deemph_level[3:2] == $past(eq[1][5:4])) // R6
		else $error("lane 2 de-emphasis level wrong");
	a_config_lane_on: assert property (lane_on[config_lane]) // R9
		else $error("config lane is off");
	a_noncfg_low_power: assert property (link_state != 2'(RLC_U0) |->
		!lane_on[~config_lane]) // R10
		else $error("non-config lane on in low power");
	a_sleep_disc_off: assert property ($past(!s_sleep_n && next_state == RLC_DISC) |->
		rx_term_en == 2'b00 && !rx_detect_en) // R14
		else $error("terminations left on while asleep in disconnect");
	a_u3_no_wake: assert property (state == RLC_U23 && !s_sleep_n |=>
		state == RLC_U23) // R13
		else $error("left U3 while asleep");
	a_u23_lfps_wake: assert property (state == RLC_U23 && s_sleep_n && term_ok && lfps_cfg
		|=> state == RLC_U0 && lane_on[~config_lane] == dual_lane_active) // R18
		else $error("no wake on signaling in U2/U3");
	a_strap_frozen: assert property (strap_done |=> $stable(serial_mode)
		&& $stable(mode_reserved)) // R19
		else $error("strap decode changed after capture");

	c_u23_wake: cover property (state == RLC_U23 ##1 state == RLC_U0);
	c_dual_lane: cover property ($rose(dual_lane_active));
	c_limited_eq: cover property (host_tx_limited[1] && tx_preshoot_on[1] && tx_deemph_on[1]);
	c_sleep_disc: cover property (state == RLC_DISC && rx_term_en == 2'b00);

endmodule : rlc_lane_ctrl

// File: tb/rlc_link_partner.sv
// Far-side host and connector model driving the link sense pins
`timescale 1ns/1ns
module rlc_link_partner
#(
	parameter int LFPS_CYC = 12
)
(
	// Clock
	input  wire logic       ref_clk,
	// Commands from the bench
	input  wire logic       attached,
	input  wire logic [1:0] traffic,
	input  wire logic       wake,
	// Link sense toward the block
	output logic      [1:0] far_term_host,
	output logic      [1:0] far_term_conn,
	output logic      [1:0] lane_idle,
	output logic      [1:0] lane_lfps
);
	int burst = 0;

	// Both ends terminate together; idle follows the traffic command
	assign far_term_host = {2{attached}};
	assign far_term_conn = {2{attached}};
	assign lane_idle     = ~traffic;
	// Burst is held long enough to clear the pin filter
	assign lane_lfps     = (burst != 0) ? 2'h3 : 2'h0;

	// Wake burst length counter
	always @(posedge ref_clk)
	begin
		if (wake && burst == 0)
			burst <= LFPS_CYC;
		else if (burst != 0)
			burst <= burst - 1;
	end
endmodule : rlc_link_partner

// File: tb/tb_redriver_lane_control.sv
// Self-checking bench for the redriver lane control block
`timescale 1ns/1ns
module tb_redriver_lane_control;
	import rlc_pkg::*;
	logic       ref_clk, reset, reg_wr, reg_rd, flip_pin, system_sleep_n, attached, wake;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
	logic [1:0] mode_level_pin, traffic, far_term_host, far_term_conn, lane_idle, lane_lfps;
	logic       serial_mode, mode_reserved, config_lane, dual_lane_active, rx_detect_en;
	logic [1:0] link_state, lane_on, rx_term_en, linearity_level, host_tx_limited;
	logic [1:0] host_tx_swing_level, tx_preshoot_on, tx_deemph_on;
	logic [3:0] tx_preshoot_level, tx_deemph_level;
	int         failures = 0;
	int         samples_checked = 0;
	int         cycles = 0;

	rlc_lane_ctrl rlc_lane_ctrl_i (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mode_level_pin(mode_level_pin), .flip_pin(flip_pin), .system_sleep_n(system_sleep_n),
		.far_term_host(far_term_host), .far_term_conn(far_term_conn), .lane_idle(lane_idle),
		.lane_lfps(lane_lfps), .serial_mode(serial_mode), .mode_reserved(mode_reserved),
		.config_lane(config_lane), .link_state(link_state), .dual_lane_active(dual_lane_active),
		.lane_on(lane_on), .rx_term_en(rx_term_en), .rx_detect_en(rx_detect_en),
		.linearity_level(linearity_level), .host_tx_limited(host_tx_limited),
		.host_tx_swing_level(host_tx_swing_level), .tx_preshoot_on(tx_preshoot_on),
		.tx_preshoot_level(tx_preshoot_level), .tx_deemph_on(tx_deemph_on),
		.tx_deemph_level(tx_deemph_level));

	rlc_link_partner rlc_link_partner_i (.ref_clk(ref_clk), .attached(attached),
		.traffic(traffic), .wake(wake), .far_term_host(far_term_host),
		.far_term_conn(far_term_conn), .lane_idle(lane_idle), .lane_lfps(lane_lfps));

	// Free-running 50 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	// Hang guard, well above the expected run length
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			test_done();
		end
	end

	task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic ticks(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : ticks

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		ticks(3);
	endtask : reg_write

	task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : reg_read

	// Reset with a given mode strap, checking values held in reset
	task automatic do_reset(input logic [1:0] mode);
		@(posedge ref_clk);
		reset <= 1'b1;
		mode_level_pin <= mode;
		ticks(16);
		check("rst_lane_on", lane_on, 8'h01);
		check("rst_term", rx_term_en, 8'h03);
		check("rst_lin", linearity_level, 8'h03);
		check("rst_limited", host_tx_limited, 8'h00);
		reset <= 1'b0;
		ticks(10);
		check("mode_serial", serial_mode, {7'h00, mode == LVL_F});
		check("mode_rsvd", mode_reserved, {7'h00, mode == LVL_0 || mode == LVL_R});
	endtask : do_reset

	// Register reset values and all four linearity ranges
	task automatic t_regs;
		reg_read(REG_CTRL, rd);
		check("ctrl", rd, CTRL_RESET);
		reg_read(REG_LANE2_EQ, rd);
		check("lane2_eq", rd, EQ_RESET);
		reg_read(8'h20, rd);
		check("unmapped", rd, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			reg_write(REG_CTRL, 8'h10 | 8'(i << 1));
			check("lin", linearity_level, 8'(i));
			check("lim_off", host_tx_limited, 8'h00);
		end
	endtask : t_regs

	// Limited mode gates swing and transmit equalisation
	task automatic t_limited;
		reg_write(REG_SWING, 8'h02);
		reg_write(REG_LANE1_EQ, 8'h65);
		reg_write(REG_LANE2_EQ, 8'h73);
		check("ps_gated", tx_preshoot_on, 8'h00);
		reg_write(REG_CTRL, 8'h17);
		check("limited", host_tx_limited, 8'h03);
		check("swing", host_tx_swing_level, 8'h02);
		check("ps_on", tx_preshoot_on, 8'h01);
		check("ps_lvl", tx_preshoot_level, 8'h01);
		check("de_on", tx_deemph_on, 8'h03);
		check("de_lvl", tx_deemph_level, 8'h0E);
		reg_write(REG_CTRL, CTRL_RESET);
		check("lim_clr", host_tx_limited, 8'h00);
		check("ps_clr", tx_preshoot_on, 8'h00);
	endtask : t_limited

	// Power states, dual-lane detect and orientation
	task automatic t_link;
		attached <= 1'b1;
		traffic <= 2'h3;
		ticks(8);
		check("u0", link_state, RLC_U0);
		check("dual", dual_lane_active, 8'h01);
		check("both_on", lane_on, 8'h03);
		traffic <= 2'h0;
		ticks(8);
		check("u1", link_state, RLC_U1);
		check("nc_off", lane_on, 8'h01);
		ticks(55);
		check("u23", link_state, RLC_U23);
		check("det_u23", rx_detect_en, 8'h01);
		wake <= 1'b1;
		traffic <= 2'h3;
		@(posedge ref_clk);
		wake <= 1'b0;
		ticks(8);
		check("wake", link_state, RLC_U0);
		check("nc_back", lane_on, 8'h03);
		reg_write(REG_CTRL, 8'h1E);
		check("flip", config_lane, 8'h01);
		traffic <= 2'h1;
		ticks(8);
		check("u1_flip", link_state, RLC_U1);
		check("cfg2_on", lane_on, 8'h02);
		reg_write(REG_CTRL, CTRL_RESET);
		attached <= 1'b0;
		ticks(8);
		check("disc", link_state, RLC_DISC);
		attached <= 1'b1;
		ticks(8);
		check("single", dual_lane_active, 8'h00);
		check("single_on", lane_on, 8'h01);
		reg_read(REG_STATUS, rd);
		check("status", rd, 8'h11);
	endtask : t_link

	// Sleep pin in U3 and in disconnect
	task automatic t_sleep;
		traffic <= 2'h0;
		ticks(70);
		system_sleep_n <= 1'b0;
		ticks(8);
		check("sl_det", rx_detect_en, 8'h00);
		check("sl_term", rx_term_en, 8'h03);
		reg_read(REG_STATUS, rd);
		check("sl_status", rd, 8'h93);
		wake <= 1'b1;
		@(posedge ref_clk);
		wake <= 1'b0;
		ticks(10);
		check("no_wake", link_state, RLC_U23);
		system_sleep_n <= 1'b1;
		attached <= 1'b0;
		ticks(8);
		system_sleep_n <= 1'b0;
		ticks(8);
		check("disc_term", rx_term_en, 8'h00);
		check("disc_det", rx_detect_en, 8'h00);
		system_sleep_n <= 1'b1;
		ticks(8);
		check("resume_det", rx_detect_en, 8'h01);
		check("resume_term", rx_term_en, 8'h03);
	endtask : t_sleep

	// Strap mode, late strap change and reserved levels
	task automatic t_strap;
		flip_pin <= 1'b1;
		do_reset(LVL_1);
		check("st_lin", linearity_level, LIN_TOP);
		check("st_flip", config_lane, 8'h01);
		reg_write(REG_LANE1_EQ, 8'h65);
		reg_write(REG_CTRL, 8'h17);
		check("st_lim", host_tx_limited, 8'h00);
		check("st_ps", tx_preshoot_on, 8'h00);
		mode_level_pin <= LVL_F;
		ticks(10);
		check("st_hold", serial_mode, 8'h00);
		flip_pin <= 1'b0;
		do_reset(LVL_0);
		do_reset(LVL_R);
	endtask : t_strap

	// Main sequence
	initial
	begin
		reset = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		mode_level_pin = LVL_F;
		flip_pin = 1'b0;
		system_sleep_n = 1'b1;
		attached = 1'b0;
		traffic = 2'h0;
		wake = 1'b0;
		do_reset(LVL_F);
		t_regs();
		t_limited();
		t_link();
		t_sleep();
		t_strap();
		test_done();
	end
endmodule : tb_redriver_lane_control
